// file: verilog/mbmap_defines.vh
// Constants for the object register map behind the protocol engine.
// Assumes register numbers arrive as one-based standard numbers.
// Functional notes
// - Holding 1-400 read objects signed 16-bit; input 1-400 unsigned 16-bit.
// - Holding 1001-1400 unsigned 16-bit; input 1001-1400 signed 16-bit.
// - Registers 2001-2800 give objects as raw 32-bit words, not converted to float, two registers each.
// - Registers 3001-3800 give objects as signed 32-bit, two registers each.
// - Coils and discrete inputs 1-400 give one bit per object.
// - All views share one object store; writes show through every view.
// - Holding 6001-6050 report remote device status codes 0 to 5.
// - Holding 7001-7300 report network variable status codes 0 to 3.
// - Holding 8001-8246 hold last error per slave 1-246.
// - Error register reads 0, exception code, 129 no response, 130 CRC.
`ifndef MBMAP_DEFINES_VH
`define MBMAP_DEFINES_VH
`define MBMAP_S16_BASE 16'h0001
`define MBMAP_U16_BASE 16'h03e9
`define MBMAP_FLT_BASE 16'h07d1
`define MBMAP_S32_BASE 16'h0bb9
`define MBMAP_DEV_BASE 16'h1771
`define MBMAP_NV_BASE 16'h1b59
`define MBMAP_ERR_BASE 16'h1f41
`define MBMAP_NUM_OBJ 16'h0190
`define MBMAP_NUM_DEV 16'h0032
`define MBMAP_NUM_NV 16'h012c
`define MBMAP_NUM_ERR 16'h00f6
`define MBMAP_NUM_WIDE 16'h0320
`define MBMAP_SLAVE_FIRST 8'h01
`define MBMAP_SP_COIL 2'h0
`define MBMAP_SP_DISC 2'h1
`define MBMAP_SP_INPUT 2'h2
`define MBMAP_SP_HOLD 2'h3
`define MBMAP_EXC_NONE 8'h00
`define MBMAP_EXC_ADDR 8'h02
`define MBMAP_ERR_NORESP 8'h81
`define MBMAP_ERR_CRC 8'h82
`define MBMAP_DEV_MAX 3'h5
`define MBMAP_NV_MAX 2'h3
`endif

// file: verilog/mbmap_ram.v
// Small store: one word per entry, registered read data.
// Assumes a single clock; one read and one write port.
module mbmap_ram #(
	parameter DEPTH = 400,
	parameter AW = 9,
	parameter DW = 32
) (
	input wire clk_in,
	input wire wr_en_in,
	input wire [AW-1:0] wr_addr_in,
	input wire [DW-1:0] wr_data_in,
	input wire [AW-1:0] rd_addr_in,
	output reg [DW-1:0] rd_data_out
);
	reg [DW-1:0] mem [0:DEPTH-1];
	always @(posedge clk_in) begin
		if (wr_en_in)
			mem[wr_addr_in] <= wr_data_in;
		rd_data_out <= mem[rd_addr_in];
	end
endmodule

// file: verilog/mbmap_top.v
// Register map of the gateway's object and diagnostic space.
// Assumes a protocol engine presents one decoded request at a time.
`include "mbmap_defines.vh"
module mbmap_top (
	// Clock and reset
	input wire clk_sys_in,
	input wire rst_n_in,
	// Request from the protocol engine
	input wire req_valid_in,
	input wire req_write_in,
	input wire req_wide_in,
	input wire [1:0] req_space_in,
	input wire [15:0] req_regno_in,
	input wire [31:0] req_wdata_in,
	// Answer to the protocol engine
	output reg rsp_valid_out,
	output reg [31:0] rsp_rdata_out,
	output reg [7:0] rsp_exc_out,
	// Diagnostic status updates from the gateway engine
	input wire dev_stat_we_in,
	input wire [5:0] dev_stat_idx_in,
	input wire [2:0] dev_stat_code_in,
	input wire nv_stat_we_in,
	input wire [8:0] nv_stat_idx_in,
	input wire [1:0] nv_stat_code_in,
	input wire err_we_in,
	input wire [7:0] err_slave_in,
	input wire [7:0] err_code_in
);
	reg rst_s1_r, rst_s2_r;
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end
	wire rst_n = rst_s2_r;

	// Address decode
	reg hit_obj, hit_diag, wide_view, is_hi, is_signed, addr_ok;
	reg [15:0] off;
	reg [15:0] doff;
	reg [8:0] obj_idx;
	reg [1:0] dkind;
	reg [8:0] didx;
	always @* begin
		hit_obj = 1'b0;
		hit_diag = 1'b0;
		wide_view = 1'b0;
		is_hi = 1'b0;
		is_signed = 1'b0;
		off = 16'h0000;
		doff = 16'h0000;
		dkind = 2'h0;
		didx = 9'h000;
		if (req_space_in == `MBMAP_SP_COIL || req_space_in == `MBMAP_SP_DISC) begin
			off = req_regno_in - `MBMAP_S16_BASE;
			hit_obj = req_regno_in >= `MBMAP_S16_BASE && off < `MBMAP_NUM_OBJ;
		end else if (req_regno_in >= `MBMAP_S16_BASE &&
				req_regno_in < `MBMAP_S16_BASE + `MBMAP_NUM_OBJ) begin
			off = req_regno_in - `MBMAP_S16_BASE;
			hit_obj = 1'b1;
			is_signed = (req_space_in == `MBMAP_SP_HOLD);
		end else if (req_regno_in >= `MBMAP_U16_BASE &&
				req_regno_in < `MBMAP_U16_BASE + `MBMAP_NUM_OBJ) begin
			off = req_regno_in - `MBMAP_U16_BASE;
			hit_obj = 1'b1;
			is_signed = (req_space_in == `MBMAP_SP_INPUT);
		end else if (req_regno_in >= `MBMAP_FLT_BASE &&
				req_regno_in < `MBMAP_FLT_BASE + `MBMAP_NUM_WIDE) begin
			off = (req_regno_in - `MBMAP_FLT_BASE) >> 1;
			// First register of a pair is odd and carries the high half
			is_hi = req_regno_in[0];
			hit_obj = 1'b1;
			wide_view = 1'b1;
		end else if (req_regno_in >= `MBMAP_S32_BASE &&
				req_regno_in < `MBMAP_S32_BASE + `MBMAP_NUM_WIDE) begin
			off = (req_regno_in - `MBMAP_S32_BASE) >> 1;
			is_hi = req_regno_in[0];
			hit_obj = 1'b1;
			wide_view = 1'b1;
		end else if (req_space_in == `MBMAP_SP_HOLD) begin
			if (req_regno_in >= `MBMAP_DEV_BASE &&
					req_regno_in < `MBMAP_DEV_BASE + `MBMAP_NUM_DEV) begin
				hit_diag = 1'b1;
				dkind = 2'h0;
				doff = req_regno_in - `MBMAP_DEV_BASE;
			end else if (req_regno_in >= `MBMAP_NV_BASE &&
					req_regno_in < `MBMAP_NV_BASE + `MBMAP_NUM_NV) begin
				hit_diag = 1'b1;
				dkind = 2'h1;
				doff = req_regno_in - `MBMAP_NV_BASE;
			end else if (req_regno_in >= `MBMAP_ERR_BASE &&
					req_regno_in < `MBMAP_ERR_BASE + `MBMAP_NUM_ERR) begin
				hit_diag = 1'b1;
				dkind = 2'h2;
				doff = req_regno_in - `MBMAP_ERR_BASE;
			end
		end
		obj_idx = off[8:0];
		didx = doff[8:0];
		// Wide views start on the odd register; diagnostics are read only
		addr_ok = (hit_obj && (!wide_view || (req_wide_in && is_hi))) ||
			(hit_diag && !req_write_in);
	end

	// Write conversion into the shared store, kept as signed 32-bit
	reg [31:0] wval;
	always @* begin
		if (req_space_in == `MBMAP_SP_COIL)
			wval = {31'h00000000, req_wdata_in[0]};
		else if (!wide_view)
			wval = is_signed ? {{16{req_wdata_in[15]}}, req_wdata_in[15:0]} :
				{16'h0000, req_wdata_in[15:0]};
		else
			wval = req_wdata_in;
	end
	// Float writes are stored as raw words; float reads of integers pass raw too
	wire wr_ok = req_valid_in && req_write_in && addr_ok &&
		(req_space_in == `MBMAP_SP_HOLD || req_space_in == `MBMAP_SP_COIL);
	wire [31:0] rd_word;
	mbmap_ram #(
		.DEPTH(`MBMAP_NUM_OBJ),
		.AW(9),
		.DW(32)
	) u_ram (
		.clk_in(clk_sys_in),
		.wr_en_in(wr_ok),
		.wr_addr_in(obj_idx),
		.wr_data_in(wval),
		.rd_addr_in(obj_idx),
		.rd_data_out(rd_word)
	);

	// Diagnostic tables, one store each; entries read undefined until first written
	wire dev_ok = dev_stat_we_in && {10'h000, dev_stat_idx_in} < `MBMAP_NUM_DEV &&
		dev_stat_code_in <= `MBMAP_DEV_MAX;
	wire nv_ok = nv_stat_we_in && {7'h00, nv_stat_idx_in} < `MBMAP_NUM_NV &&
		nv_stat_code_in <= `MBMAP_NV_MAX;
	// Slave numbers are one-based; zero and numbers past the table are dropped
	wire err_ok = err_we_in && err_slave_in >= `MBMAP_SLAVE_FIRST &&
		{8'h00, err_slave_in} <= `MBMAP_NUM_ERR;
	wire [7:0] err_wr_idx = err_slave_in - `MBMAP_SLAVE_FIRST;
	wire [2:0] dev_word;
	wire [1:0] nv_word;
	wire [7:0] err_word;
	mbmap_ram #(
		.DEPTH(`MBMAP_NUM_DEV),
		.AW(6),
		.DW(3)
	) u_dev_ram (
		.clk_in(clk_sys_in),
		.wr_en_in(dev_ok),
		.wr_addr_in(dev_stat_idx_in),
		.wr_data_in(dev_stat_code_in),
		.rd_addr_in(didx[5:0]),
		.rd_data_out(dev_word)
	);
	mbmap_ram #(
		.DEPTH(`MBMAP_NUM_NV),
		.AW(9),
		.DW(2)
	) u_nv_ram (
		.clk_in(clk_sys_in),
		.wr_en_in(nv_ok),
		.wr_addr_in(nv_stat_idx_in),
		.wr_data_in(nv_stat_code_in),
		.rd_addr_in(didx),
		.rd_data_out(nv_word)
	);
	mbmap_ram #(
		.DEPTH(`MBMAP_NUM_ERR),
		.AW(8),
		.DW(8)
	) u_err_ram (
		.clk_in(clk_sys_in),
		.wr_en_in(err_ok),
		.wr_addr_in(err_wr_idx),
		.wr_data_in(err_code_in), // Codes kept as the engine gives them
		.rd_addr_in(didx[7:0]),
		.rd_data_out(err_word)
	);

	// Pipeline: request stage, then answer stage once the stores have read
	reg p_v_r, p_ok_r, p_diag_r, p_wide_r, p_bit_r;
	reg [1:0] p_kind_r;
	reg [31:0] diag_word;
	always @* begin
		case (p_kind_r)
			2'h0: diag_word = {29'h00000000, dev_word};
			2'h1: diag_word = {30'h00000000, nv_word};
			2'h2: diag_word = {24'h000000, err_word};
			default: diag_word = 32'h00000000;
		endcase
	end
	always @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			p_v_r <= 1'b0;
			p_ok_r <= 1'b0;
			p_diag_r <= 1'b0;
			p_wide_r <= 1'b0;
			p_bit_r <= 1'b0;
			p_kind_r <= 2'h0;
			rsp_valid_out <= 1'b0;
			rsp_rdata_out <= 32'h00000000;
			rsp_exc_out <= `MBMAP_EXC_NONE;
		end else begin
			p_v_r <= req_valid_in;
			p_ok_r <= addr_ok;
			p_diag_r <= hit_diag;
			p_wide_r <= wide_view;
			p_bit_r <= req_space_in == `MBMAP_SP_COIL || req_space_in == `MBMAP_SP_DISC;
			p_kind_r <= dkind;
			rsp_valid_out <= p_v_r;
			if (p_v_r) begin
				rsp_exc_out <= p_ok_r ? `MBMAP_EXC_NONE : `MBMAP_EXC_ADDR;
				if (!p_ok_r)
					rsp_rdata_out <= 32'h00000000;
				else if (p_diag_r)
					rsp_rdata_out <= diag_word;
				else if (p_bit_r)
					rsp_rdata_out <= {31'h00000000, rd_word != 32'h00000000};
				else if (p_wide_r)
					rsp_rdata_out <= rd_word;
				else
					rsp_rdata_out <= {16'h0000, rd_word[15:0]};
			end
		end
	end
endmodule

// file: sim/mbmap_checker.sv
// Bound checker on the object map request and answer ports.
// Assumes requests follow the two-cycle answer timing.
module mbmap_checker (
	input wire clk_sys_in, rst_n_in, req_valid_in, req_write_in, req_wide_in,
	input wire [1:0] req_space_in,
	input wire [15:0] req_regno_in,
	input wire rsp_valid_out,
	input wire [7:0] rsp_exc_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	wire r = req_valid_in && !req_write_in;
	wire h = req_valid_in && req_space_in == 2'h3;
	wire [15:0] n = req_regno_in;
	sequence s_ok; ##2 rsp_valid_out && rsp_exc_out == 8'h00; endsequence
	sequence s_no; ##2 rsp_valid_out && rsp_exc_out == 8'h02; endsequence
	property p_s16; h && r && n inside {[16'h0001:16'h0190]} |-> s_ok; endproperty
	a_s16: assert property (p_s16) else $error("s16");
	property p_u16; h && r && n inside {[16'h03e9:16'h0578]} |-> s_ok; endproperty
	a_u16: assert property (p_u16) else $error("u16");
	property p_flt; r && req_space_in[1] && req_wide_in && n == 16'h07d3 |-> s_ok; endproperty
	a_flt: assert property (p_flt) else $error("flt");
	property p_s32; r && req_wide_in && n == 16'h0bba |-> s_no; endproperty
	a_s32: assert property (p_s32) else $error("s32");
	property p_coil; req_valid_in && req_space_in == 2'h0 && n == 16'h0191 |-> s_no; endproperty
	a_coil: assert property (p_coil) else $error("coil");
	property p_dev; h && req_write_in && n == 16'h1771 |-> s_no; endproperty
	a_dev: assert property (p_dev) else $error("dev");
	property p_err; h && r && n == 16'h2037 |-> s_no; endproperty
	a_err: assert property (p_err) else $error("err");
	property p_gap; h && n inside {[16'h0191:16'h03e8]} |-> s_no; endproperty
	a_gap: assert property (p_gap) else $error("gap");
endmodule
bind mbmap_top mbmap_checker u_chk (.*);

// file: sim/mbmap_eng_model.sv
// Protocol engine model issuing one decoded request at a time.
// Assumes the map answers two cycles after the taking edge.
module mbmap_eng_model (
	input wire clk_sys_in, rsp_valid_out,
	input wire [31:0] rsp_rdata_out,
	input wire [7:0] rsp_exc_out,
	output logic req_valid_in = 1'b0, req_write_in = 1'b0, req_wide_in = 1'b0,
	output logic [1:0] req_space_in = 2'h0,
	output logic [15:0] req_regno_in = 16'h0,
	output logic [31:0] req_wdata_in = 32'h0
);
	timeunit 1ns;
	timeprecision 1ps;
	task xfer(input logic w, k, input logic [1:0] p, input logic [15:0] n,
		input logic [31:0] v, output logic [31:0] q, output logic [7:0] x);
		int c;
		@(posedge clk_sys_in);
		req_valid_in <= 1'b1;
		req_write_in <= w;
		req_wide_in <= k; // Both halves in one request
		req_space_in <= p;
		req_regno_in <= n;
		req_wdata_in <= v;
		@(posedge clk_sys_in);
		req_valid_in <= 1'b0;
		req_wdata_in <= ~v; // Released data must not look valid
		c = 0;
		do begin
			@(posedge clk_sys_in);
			c++;
		end while (!rsp_valid_out && c < 4);
		q = rsp_rdata_out;
		// No answer in time shows as a code no request expects
		x = rsp_valid_out ? rsp_exc_out : 8'hff;
	endtask
endmodule

// file: sim/testbench.sv
// Self-checking bench for the object register map.
// Assumes the engine model drives requests; diagnostics driven here.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_in = 1'b0, rst_n_in = 1'b0;
	logic dev_stat_we_in = 1'b0, nv_stat_we_in = 1'b0, err_we_in = 1'b0;
	logic [5:0] dev_stat_idx_in = 6'h0;
	logic [2:0] dev_stat_code_in = 3'h0;
	logic [8:0] nv_stat_idx_in = 9'h0;
	logic [1:0] nv_stat_code_in = 2'h0, req_space_in;
	logic [7:0] err_slave_in = 8'h0, err_code_in = 8'h0, rsp_exc_out, e;
	logic req_valid_in, req_write_in, req_wide_in, rsp_valid_out;
	logic [15:0] req_regno_in;
	logic [31:0] req_wdata_in, rsp_rdata_out, d;
	int bad_count = 0, checks_done = 0;
	always #4 clk_sys_in = ~clk_sys_in;
	mbmap_top dut (.*);
	mbmap_eng_model eng (.*);
	task chk(input string s, input logic [31:0] x, y);
		checks_done++;
		if (x !== y) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", s, x, y);
		end
	endtask
	task go(input logic w, input logic [1:0] p, input logic [15:0] n, input logic k,
		input logic [31:0] v, input logic [7:0] x);
		eng.xfer(w, k, p, n, v, d, e);
		chk("exc", {24'h0, x}, {24'h0, e});
		if (!w && x == 8'h0)
			chk("data", v, d & (p < 2'h2 ? 32'h1 : k ? 32'hffffffff : 32'hffff));
	endtask
	task stop_test;
		$display("checks %0d errors %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge clk_sys_in);
		bad_count++;
		stop_test;
	end
	initial begin
		repeat (4) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		repeat (3) @(posedge clk_sys_in);
		go(1'b1, 2'h3, 16'h0001, 1'b0, 32'hffff, 8'h0);
		go(1'b0, 2'h2, 16'h0001, 1'b0, 32'hffff, 8'h0);
		go(1'b0, 2'h3, 16'h03e9, 1'b0, 32'hffff, 8'h0);
		go(1'b0, 2'h3, 16'h0bb9, 1'b1, 32'hffffffff, 8'h0);
		go(1'b1, 2'h3, 16'h07d3, 1'b1, 32'h3fc00000, 8'h0);
		go(1'b0, 2'h2, 16'h07d3, 1'b1, 32'h3fc00000, 8'h0);
		go(1'b0, 2'h3, 16'h0002, 1'b0, 32'h0, 8'h0);
		go(1'b1, 2'h0, 16'h0002, 1'b0, 32'h0, 8'h0);
		go(1'b0, 2'h1, 16'h0002, 1'b0, 32'h0, 8'h0);
		go(1'b0, 2'h0, 16'h0001, 1'b0, 32'h1, 8'h0);
		dev_stat_we_in <= 1'b1;
		dev_stat_code_in <= 3'h5;
		nv_stat_we_in <= 1'b1;
		nv_stat_idx_in <= 9'h12b;
		nv_stat_code_in <= 2'h3;
		err_we_in <= 1'b1;
		err_slave_in <= 8'hf6;
		err_code_in <= 8'h82;
		@(posedge clk_sys_in);
		{dev_stat_we_in, nv_stat_we_in} <= 2'h0;
		err_slave_in <= 8'h01;
		err_code_in <= 8'h81;
		@(posedge clk_sys_in);
		err_we_in <= 1'b0;
		go(1'b0, 2'h3, 16'h1f41, 1'b0, 32'h81, 8'h0);
		go(1'b0, 2'h3, 16'h1c84, 1'b0, 32'h3, 8'h0);
		go(1'b0, 2'h3, 16'h2036, 1'b0, 32'h82, 8'h0);
		go(1'b1, 2'h3, 16'h1771, 1'b0, 32'h0, 8'h2);
		go(1'b0, 2'h3, 16'h1771, 1'b0, 32'h5, 8'h0);
		go(1'b1, 2'h3, 16'h01f4, 1'b0, 32'h1, 8'h2);
		go(1'b0, 2'h3, 16'h2037, 1'b0, 32'h0, 8'h2);
		go(1'b0, 2'h2, 16'h0bba, 1'b1, 32'h0, 8'h2);
		go(1'b0, 2'h0, 16'h0191, 1'b0, 32'h0, 8'h2);
		stop_test;
	end
endmodule
